// File: rtl/lcd_char_instruction_decoder.sv
`timescale 1ns/10ps
// How it works
// - Select low write 0001xxxx: shift, bit3 target, bit2 direction, RAM kept
// - Target set shifts display, clear moves cursor; direction set is right
// - Function-set width bit picks eight-bit or four-bit host transfers
// - Until any other command, line bit picks two lines; font bit picks 5x10 over 5x7
// - Bit7 low bit6 high loads glyph RAM address; data then targets glyph RAM
// - Bit7 high loads text RAM address; data then targets text RAM
// - Status read returns busy flag and address counter instantly, even busy
// - Data write stores to addressed RAM; counter steps 4.7 us after done
// - Data read returns addressed RAM byte; counter steps like a write
// - Ordinary commands finish within 31 us at 125 MHz reference
// - Clear fills text RAM with 20h, cancels shift, zeroes counter
// - Clear forces increment; blink and shift mode kept
// - Home cancels shift and zeroes counter, RAM kept
// - Direction bit set increments counter on data access, else decrements
// - Shift bit set shifts display on each text RAM write
// - No display shift on text reads or glyph accesses; counter still steps
// - Display bit turns display on or off; counter and RAM untouched
// - Cursor bit shows or hides cursor; entry settings untouched
// - Blink alternates cursor cell every 320 ms at 125 MHz
// - Clear is 00000001, home 0000001x; both take up to 1.28 ms
// - Entry is 000001 plus two bits; display control 00001 plus three
// - Four-bit mode moves each byte as two transfers on upper lines
module lcd_char_instruction_decoder
   import lcd_pkg::*;
#(
   parameter int CLEAR_CYCLES = lcd_pkg::CLEAR_CYC,
   parameter int BLINK_CYCLES = lcd_pkg::BLINK_CYC
) (
   // Clock and reset
   input  wire logic              REF_CLK_I,
   input  wire logic              RESETN_I,
   // Host side
   input  wire logic              STROBE_I,
   input  wire lcd_pkg::host_req_s HOST_REQ_I,
   output logic [7:0]             DATA_O,
   output logic                   BUSY_O,
   // Display side
   output lcd_pkg::disp_cfg_s     CFG_O,
   output logic                   ENTRY_INC_O,
   output logic                   ENTRY_SHIFT_O,
   output logic [5:0]             SHIFT_OFFSET_O,
   output logic [6:0]             ADDR_COUNTER_O,
   output logic                   GLYPH_TARGET_O,
   output logic                   BLINK_PHASE_O,
   input  wire logic [6:0]        SCAN_ADDR_I,
   output logic [7:0]             SCAN_DATA_O,
   input  wire logic [5:0]        GLYPH_ADDR_I,
   output logic [7:0]             GLYPH_DATA_O
);
   import lcd_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      state_e                 state;
      logic [CNT_W-1:0]       cnt;
      logic [CNT_W-1:0]       blink_cnt;
      logic                   blink_phase;
      disp_cfg_s              cfg;
      logic                   font_lock;
      logic                   entry_inc;
      logic                   entry_shift;
      logic [5:0]             offset;
      logic [6:0]             addr_counter;
      logic                   glyph_target;
      logic                   step_pend;
      logic                   nib_phase;
      logic [3:0]             nib_hold;
      logic [7:0]             rd_byte;
      logic [7:0]             data_out;
      logic [TEXT_DEPTH-1:0][7:0]  text_ram;
      logic [GLYPH_DEPTH-1:0][7:0] glyph_ram;
   } core_s;

   core_s st_r;
   core_s st_nxt;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic cmd_e decode(input logic [7:0] b);
      cmd_e c;
      c = C_NONE;
      if (b[7])                   c = C_TEXT;
      else if (b[6])              c = C_GLYPH;
      else if (b[5])              c = C_FUNC;
      else if (b[4])              c = C_SHIFT;
      else if (b[3])              c = C_DISP;
      else if (b[2])              c = C_ENTRY;
      else if (b[1])              c = C_HOME;
      else if (b[0])              c = C_CLEAR;
      return c;
   endfunction : decode

   // Counter step wraps inside the addressed RAM
   function automatic logic [6:0] step_ac(input logic [6:0] a,
                                          input logic       up,
                                          input logic       glyph);
      logic [6:0] r;
      if (glyph)
         r = up ? ((a + 7'h01) & GLYPH_MASK) : ((a - 7'h01) & GLYPH_MASK);
      else if (up)
         r = (a >= TEXT_LAST) ? 7'h00 : a + 7'h01;
      else
         r = (a == 7'h00 || a > TEXT_LAST) ? TEXT_LAST : a - 7'h01;
      return r;
   endfunction : step_ac

   // Left shift moves text left, so the window origin advances
   function automatic logic [5:0] step_off(input logic [5:0] o,
                                           input logic       right);
      logic [5:0] r;
      if (!right)
         r = (o >= SHIFT_LAST) ? 6'h00 : o + 6'h01;
      else
         r = (o == 6'h00) ? SHIFT_LAST : o - 6'h01;
      return r;
   endfunction : step_off

   // ------------------------------------------------------------
   // Host framing
   // ------------------------------------------------------------
   logic       status_rd;
   logic       full_byte;
   logic [7:0] byte_in;
   logic       second_rd;
   logic       accept;
   cmd_e       cmd;

   assign status_rd = STROBE_I && !HOST_REQ_I.register_select
                      && HOST_REQ_I.read;
   // Four-bit writes pair high nibble first, then low
   assign full_byte = st_r.cfg.bus_width_sel || st_r.nib_phase;
   assign byte_in   = st_r.cfg.bus_width_sel ? HOST_REQ_I.data
                      : {st_r.nib_hold, HOST_REQ_I.data[7:4]};
   assign second_rd = !st_r.cfg.bus_width_sel && st_r.nib_phase;
   // Busy drops non-status strobes; no phase change either
   assign accept = STROBE_I && (status_rd || st_r.state != ST_EXEC);
   assign cmd    = decode(byte_in);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [6:0] ac;
      logic       run;
      logic       long_run;
      ac       = st_r.addr_counter;
      run      = 1'b0;
      long_run = 1'b0;
      st_nxt   = st_r;

      // Blink timer runs only while blink is on
      if (!st_r.cfg.blink_on) begin
         st_nxt.blink_cnt   = '0;
         st_nxt.blink_phase = 1'b0;
      end else if (st_r.blink_cnt >= CNT_W'(BLINK_CYCLES - 1)) begin
         st_nxt.blink_cnt   = '0;
         st_nxt.blink_phase = !st_r.blink_phase;
      end else begin
         st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
      end

      case (st_r.state)
         ST_IDLE: begin
         end
         ST_EXEC: begin
            if (st_r.cnt <= CNT_W'(1)) begin
               st_nxt.cnt   = CNT_W'(TADD_CYC);
               st_nxt.state = st_r.step_pend ? ST_STEP : ST_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         ST_STEP: begin
            if (st_r.cnt <= CNT_W'(1)) begin
               st_nxt.addr_counter = step_ac(st_r.addr_counter,
                  st_r.entry_inc, st_r.glyph_target);
               st_nxt.step_pend = 1'b0;
               st_nxt.state     = ST_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase

      if (accept && !status_rd && st_r.state == ST_STEP) begin
         // An early command first settles the pending step
         ac = step_ac(st_r.addr_counter, st_r.entry_inc,
                      st_r.glyph_target);
         st_nxt.addr_counter = ac;
         st_nxt.step_pend    = 1'b0;
         st_nxt.state        = ST_IDLE;
      end

      if (accept && status_rd) begin
         // Snapshot shows the counter before any pending step
         if (second_rd) begin
            st_nxt.data_out = {st_r.rd_byte[3:0], 4'h0};
         end else begin
            st_nxt.data_out = {st_r.state == ST_EXEC,
                               st_r.addr_counter};
            st_nxt.rd_byte  = {st_r.state == ST_EXEC,
                               st_r.addr_counter};
         end
         st_nxt.nib_phase = !st_r.cfg.bus_width_sel && !st_r.nib_phase;
      end else if (accept && HOST_REQ_I.read) begin
         if (second_rd) begin
            st_nxt.data_out = {st_r.rd_byte[3:0], 4'h0};
         end else begin
            st_nxt.rd_byte  = st_r.glyph_target ? st_r.glyph_ram[ac[5:0]]
                              : st_r.text_ram[ac];
            st_nxt.data_out = st_r.glyph_target ? st_r.glyph_ram[ac[5:0]]
                              : st_r.text_ram[ac];
            st_nxt.step_pend = 1'b1;
            run = 1'b1;
         end
         st_nxt.nib_phase = !st_r.cfg.bus_width_sel && !st_r.nib_phase;
      end else if (accept && !full_byte) begin
         st_nxt.nib_hold  = HOST_REQ_I.data[7:4];
         st_nxt.nib_phase = 1'b1;
      end else if (accept) begin
         st_nxt.nib_phase = 1'b0;
         run = 1'b1;
         if (HOST_REQ_I.register_select) begin
            if (st_r.glyph_target)
               st_nxt.glyph_ram[ac[5:0]] = byte_in;
            else
               st_nxt.text_ram[ac] = byte_in;
            if (st_r.entry_shift && !st_r.glyph_target)
               st_nxt.offset = step_off(st_r.offset,
                                        !st_r.entry_inc);
            st_nxt.step_pend = 1'b1;
         end else begin
            if (cmd != C_FUNC)
               st_nxt.font_lock = 1'b1;
            case (cmd)
               C_CLEAR: begin
                  for (int i = 0; i < TEXT_DEPTH; i++)
                     st_nxt.text_ram[i] = SPACE_CODE;
                  st_nxt.offset       = '0;
                  st_nxt.addr_counter = '0;
                  st_nxt.glyph_target = 1'b0;
                  st_nxt.entry_inc    = 1'b1;
                  long_run            = 1'b1;
               end
               C_HOME: begin
                  st_nxt.offset       = '0;
                  st_nxt.addr_counter = '0;
                  st_nxt.glyph_target = 1'b0;
                  long_run            = 1'b1;
               end
               C_ENTRY: begin
                  st_nxt.entry_inc   = byte_in[B_INC];
                  st_nxt.entry_shift = byte_in[B_ESHIFT];
               end
               C_DISP: begin
                  st_nxt.cfg.display_on = byte_in[B_DISP];
                  st_nxt.cfg.cursor_on  = byte_in[B_CURS];
                  st_nxt.cfg.blink_on   = byte_in[B_BLINK];
               end
               C_SHIFT: begin
                  if (byte_in[B_SC])
                     st_nxt.offset = step_off(st_r.offset,
                                              byte_in[B_RL]);
                  else begin
                     st_nxt.addr_counter = step_ac(ac, byte_in[B_RL],
                                                   1'b0);
                     st_nxt.glyph_target = 1'b0;
                  end
               end
               C_FUNC: begin
                  st_nxt.cfg.bus_width_sel = byte_in[B_WIDTH];
                  if (!st_r.font_lock) begin
                     st_nxt.cfg.two_line  = byte_in[B_LINES];
                     st_nxt.cfg.font_tall = byte_in[B_FONT];
                  end
               end
               C_GLYPH: begin
                  st_nxt.addr_counter = byte_in[6:0] & GLYPH_MASK;
                  st_nxt.glyph_target = 1'b1;
               end
               C_TEXT: begin
                  st_nxt.addr_counter = byte_in[6:0];
                  st_nxt.glyph_target = 1'b0;
               end
               default: begin
               end
            endcase
         end
      end

      if (run) begin
         st_nxt.state = ST_EXEC;
         st_nxt.cnt   = long_run ? CNT_W'(CLEAR_CYCLES)
                        : CNT_W'(EXEC_CYC);
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         st_r                   <= '0;
         st_r.state             <= ST_IDLE;
         st_r.cfg.bus_width_sel <= 1'b1;
         st_r.entry_inc         <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign DATA_O         = st_r.data_out;
   assign BUSY_O         = st_r.state == ST_EXEC;
   assign CFG_O          = st_r.cfg;
   assign ENTRY_INC_O    = st_r.entry_inc;
   assign ENTRY_SHIFT_O  = st_r.entry_shift;
   assign SHIFT_OFFSET_O = st_r.offset;
   assign ADDR_COUNTER_O = st_r.addr_counter;
   assign GLYPH_TARGET_O = st_r.glyph_target;
   assign BLINK_PHASE_O  = st_r.blink_phase;
   assign SCAN_DATA_O    = (SCAN_ADDR_I > TEXT_LAST) ? 8'h00
                           : st_r.text_ram[SCAN_ADDR_I];
   assign GLYPH_DATA_O   = st_r.glyph_ram[GLYPH_ADDR_I];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   logic       cmd_wr;
   logic [CNT_W-1:0] busy_len;
   logic       busy_long;
   assign cmd_wr = accept && !HOST_REQ_I.register_select
                   && !HOST_REQ_I.read && full_byte;

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         busy_len  <= '0;
         busy_long <= 1'b0;
      end else if (st_nxt.state == ST_EXEC && st_r.state != ST_EXEC) begin
         busy_len  <= CNT_W'(1);
         busy_long <= cmd_wr && (cmd == C_CLEAR || cmd == C_HOME);
      end else if (BUSY_O) begin
         busy_len <= busy_len + 1'b1;
      end
   end

   sequence s_clear_taken;
      cmd_wr && cmd == C_CLEAR;
   endsequence

   sequence s_text_write;
      accept && HOST_REQ_I.register_select && !HOST_REQ_I.read
      && full_byte && !st_r.glyph_target;
   endsequence

   // Second nibble of a four-bit data read only hands over the low half
   a_accept_busy: assert property (
      accept && !status_rd && (HOST_REQ_I.read ? !second_rd : full_byte)
      |=> BUSY_O) else $error("busy not raised");
   a_exec_span: assert property (
      $fell(BUSY_O) && !$past(busy_long)
      |-> $past(busy_len) == CNT_W'(EXEC_CYC))
      else $error("execution time wrong");
   a_clear_effect: assert property (
      s_clear_taken |=> ADDR_COUNTER_O == 0
      && ENTRY_INC_O && SHIFT_OFFSET_O == 0
      && st_r.text_ram[TEXT_DEPTH-1] == SPACE_CODE)
      else $error("clear incomplete");
   a_home_keep: assert property (
      cmd_wr && cmd == C_HOME
      |=> ADDR_COUNTER_O == 0 && $stable(st_r.text_ram))
      else $error("home wrong");
   a_status_now: assert property (
      status_rd && st_r.cfg.bus_width_sel
      |=> DATA_O == {$past(BUSY_O), $past(st_r.addr_counter)})
      else $error("status read wrong");
   // A write taken during a pending step settles that step on its own edge
   a_step_late: assert property (
      s_text_write ##1 BUSY_O
      |-> ##1 $stable(ADDR_COUNTER_O) [*8])
      else $error("counter moved early");
   a_step_dir: assert property (
      st_r.state == ST_STEP && st_r.cnt == 1
      && !(accept && !status_rd)
      && !st_r.glyph_target && st_r.entry_inc
      && st_r.addr_counter < TEXT_LAST
      |=> ADDR_COUNTER_O == $past(ADDR_COUNTER_O) + 7'h01)
      else $error("counter step wrong");
   a_read_noshift: assert property (
      accept && HOST_REQ_I.read
      && HOST_REQ_I.register_select |=> $stable(SHIFT_OFFSET_O))
      else $error("read shifted display");
   a_write_shift: assert property (
      s_text_write ##0 ENTRY_SHIFT_O
      |=> SHIFT_OFFSET_O != $past(SHIFT_OFFSET_O))
      else $error("write did not shift");
   a_width_set: assert property (
      cmd_wr && cmd == C_FUNC
      |=> CFG_O.bus_width_sel == $past(byte_in[B_WIDTH]))
      else $error("width not set");
endmodule : lcd_char_instruction_decoder

// File: pkg/lcd_pkg.sv
package lcd_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ      = 125000;
   localparam int EXEC_NS      = 31000;
   localparam int TADD_NS      = 4700;
   localparam int CLEAR_NS     = 1280000;
   localparam int BLINK_MS     = 320;
   localparam int EXEC_CYC     = EXEC_NS * (CLK_KHZ / 1000) / 1000;
   localparam int TADD_CYC     = TADD_NS * (CLK_KHZ / 1000) / 1000;
   localparam int CLEAR_CYC    = CLEAR_NS / 1000 * (CLK_KHZ / 1000);
   localparam int BLINK_CYC    = BLINK_MS * CLK_KHZ;
   localparam int CNT_W        = 26;
   // ------------------------------------------------------------
   // Memories and codes
   // ------------------------------------------------------------
   localparam int TEXT_DEPTH   = 80;
   localparam int GLYPH_DEPTH  = 64;
   localparam int SHIFT_SPAN   = 40;
   localparam logic [6:0] TEXT_LAST  = 7'h4F;
   localparam logic [6:0] GLYPH_MASK = 7'h3F;
   localparam logic [5:0] SHIFT_LAST = 6'h27;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   // ------------------------------------------------------------
   // Command field positions
   // ------------------------------------------------------------
   localparam int B_INC        = 1;
   localparam int B_ESHIFT     = 0;
   localparam int B_DISP       = 2;
   localparam int B_CURS       = 1;
   localparam int B_BLINK      = 0;
   localparam int B_SC         = 3;
   localparam int B_RL         = 2;
   localparam int B_WIDTH      = 4;
   localparam int B_LINES      = 3;
   localparam int B_FONT       = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_STEP = 2'b11
   } state_e;

   typedef enum logic [3:0] {
      C_NONE, C_CLEAR, C_HOME, C_ENTRY, C_DISP, C_SHIFT,
      C_FUNC, C_GLYPH, C_TEXT
   } cmd_e;

   typedef struct packed {
      logic       register_select;
      logic       read;
      logic [7:0] data;
   } host_req_s;

   typedef struct packed {
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic two_line;
      logic font_tall;
      logic bus_width_sel;
   } disp_cfg_s;
endpackage : lcd_pkg

// File: bench/lcd_host_model.sv
`timescale 1ns/10ps
module lcd_host_model
   import lcd_pkg::*;
(
   // Bus
   input  wire logic          clk_i,
   input  wire logic [7:0]    data_i,
   output logic               strobe_o,
   output lcd_pkg::host_req_s req_o
);
   logic four_bit = 1'b0;
   initial begin
      strobe_o = 1'b0;
      req_o    = '0;
   end
   task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk_i);
      #1;
      strobe_o = 1'b1;
      req_o    = '{register_select: rs, read: rd, data: d};
      @(posedge clk_i);
      #1;
      strobe_o   = 1'b0;
      req_o.data = ~d;  // Released bus must not look like the last value
      @(posedge clk_i);
      #1;
      q = data_i;
   endtask : xfer
   task automatic status(output logic [7:0] q);
      logic [7:0] lo;
      xfer(1'b0, 1'b1, 8'h00, q);
      if (four_bit) begin
         xfer(1'b0, 1'b1, 8'h00, lo);
         q = {q[7:4], lo[7:4]};
      end
   endtask : status
   task automatic wait_ready();
      logic [7:0] s;
      s = 8'h80;
      // A stuck or unknown busy flag is left to the bench watchdog
      while (s[7] !== 1'b0) begin
         status(s);
      end
   endtask : wait_ready
   task automatic raw(input logic rs, input logic [7:0] d);
      logic [7:0] q;
      xfer(rs, 1'b0, d, q);
   endtask : raw
   task automatic put(input logic rs, input logic [7:0] d);
      logic [7:0] q;
      wait_ready();
      if (four_bit) begin
         xfer(rs, 1'b0, {d[7:4], 4'h0}, q);
         xfer(rs, 1'b0, {d[3:0], 4'h0}, q);
      end else begin
         xfer(rs, 1'b0, d, q);
      end
      if (!rs && d[7:5] == 3'b001) begin
         // Width may flip mid-execution, so wait it out instead of polling
         repeat (EXEC_CYC + 10) @(posedge clk_i);
         four_bit = !d[4];
      end
   endtask : put
   task automatic get(output logic [7:0] q);
      logic [7:0] lo;
      wait_ready();
      xfer(1'b1, 1'b1, 8'h00, q);
      if (four_bit) begin
         xfer(1'b1, 1'b1, 8'h00, lo);
         q = {q[7:4], lo[7:4]};
      end
   endtask : get
endmodule : lcd_host_model

// File: bench/lcd_char_instruction_decoder_test.sv
`timescale 1ns/10ps
module lcd_char_instruction_decoder_test;
   import lcd_pkg::*;
   localparam int BLK = 20;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       strobe;
   host_req_s  req;
   logic [7:0] data, scan_data, glyph_data, s;
   logic       busy, inc, eshift, gt, blink;
   disp_cfg_s  cfg;
   logic [5:0] off;
   logic [6:0] ac;
   logic [6:0] scan_addr = 7'h00;
   logic [5:0] glyph_addr = 6'h00;
   int         n_errors = 0;
   int         comparisons = 0;
   always #4 clk = ~clk;
   lcd_char_instruction_decoder #(.CLEAR_CYCLES(50), .BLINK_CYCLES(BLK))
   i_dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .STROBE_I(strobe),
      .HOST_REQ_I(req), .DATA_O(data), .BUSY_O(busy), .CFG_O(cfg),
      .ENTRY_INC_O(inc), .ENTRY_SHIFT_O(eshift), .SHIFT_OFFSET_O(off),
      .ADDR_COUNTER_O(ac), .GLYPH_TARGET_O(gt), .BLINK_PHASE_O(blink),
      .SCAN_ADDR_I(scan_addr), .SCAN_DATA_O(scan_data),
      .GLYPH_ADDR_I(glyph_addr), .GLYPH_DATA_O(glyph_data));
   lcd_host_model i_host (.clk_i(clk), .data_i(data), .strobe_o(strobe),
      .req_o(req));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string w, input logic [7:0] v, input logic [7:0] e);
      comparisons++;
      if (v !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", w, e, v);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   // Counter steps a fixed span after busy drops
   task automatic settle();
      i_host.wait_ready();
      repeat (TADD_CYC + 5) @(posedge clk);
      #1;
   endtask : settle
   task automatic cmd(input logic [7:0] c);
      i_host.put(1'b0, c);
      i_host.wait_ready();
   endtask : cmd
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_setup();
      chk("busy", 8'(busy), 8'h00);
      cmd(8'h3C);
      chk("func", 8'({cfg.two_line, cfg.font_tall,
          cfg.bus_width_sel}), 8'h07);
      cmd(8'h04);
      chk("dec", 8'(inc), 8'h00);
      cmd(8'h01);
      chk("inc", 8'(inc), 8'h01);
      chk("ac", 8'(ac), 8'h00);
      for (int a = 0; a < 80; a++) begin
         @(posedge clk);
         #1;
         scan_addr = 7'(a);
         #1;
         chk("space", scan_data, 8'h20);
      end
      $display("setup done");
   endtask : t_setup
   task automatic t_disp();
      logic p;
      int   n;
      cmd(8'h0F);
      chk("disp", 8'({cfg.display_on, cfg.cursor_on,
          cfg.blink_on}), 8'h07);
      chk("ac", 8'(ac), 8'h00);
      chk("inc", 8'(inc), 8'h01);
      for (int k = 0; k < 2; k++) begin
         p = blink;
         n = 0;
         while (blink === p && n < 100) begin
            @(posedge clk);
            #1;
            n++;
         end
      end
      chk("blink", 8'(n), 8'(BLK));
      $display("display done");
   endtask : t_disp
   task automatic t_data();
      cmd(8'h85);
      cmd(8'h07);
      chk("eshift", 8'(eshift), 8'h01);
      i_host.put(1'b1, 8'h41);
      i_host.status(s);
      chk("status", s, 8'h85);
      settle();
      scan_addr = 7'h05;
      #1;
      chk("wr", scan_data, 8'h41);
      chk("ac", 8'(ac), 8'h06);
      chk("off", 8'(off), 8'h01);
      cmd(8'h85);
      i_host.get(s);
      chk("rd", s, 8'h41);
      settle();
      chk("ac", 8'(ac), 8'h06);
      chk("off", 8'(off), 8'h01);
      $display("data done");
   endtask : t_data
   task automatic t_shift();
      logic [7:0] c;
      int         ea, eo;
      ea = 6;
      eo = 1;
      for (int k = 0; k < 4; k++) begin
         c = 8'h10 + 8'(k * 4);
         cmd(c);
         if (c[3]) eo = c[2] ? (eo + 39) % 40 : (eo + 1) % 40;
         else ea = c[2] ? ea + 1 : ea - 1;
         chk("sh ac", 8'(ac), 8'(ea));
         chk("sh off", 8'(off), 8'(eo));
         chk("sh ram", scan_data, 8'h41);
      end
      cmd(8'h02);
      chk("home ac", 8'(ac), 8'h00);
      chk("home off", 8'(off), 8'h00);
      chk("home ram", scan_data, 8'h41);
      $display("shift done");
   endtask : t_shift
   task automatic t_glyph();
      cmd(8'h43);
      chk("gt", 8'(gt), 8'h01);
      i_host.put(1'b1, 8'h1F);
      i_host.raw(1'b1, 8'hAA);
      settle();
      glyph_addr = 6'h03;
      #1;
      chk("g3", glyph_data, 8'h1F);
      glyph_addr = 6'h04;
      #1;
      chk("g4", glyph_data, 8'h00);
      chk("ac", 8'(ac), 8'h04);
      chk("off", 8'(off), 8'h00);
      $display("glyph done");
   endtask : t_glyph
   task automatic t_four();
      i_host.put(1'b0, 8'h20);
      chk("w4", 8'({cfg.bus_width_sel, cfg.two_line}), 8'h01);
      cmd(8'h92);
      i_host.status(s);
      chk("st4", s, 8'h12);
      chk("ac4", 8'(ac), 8'h12);
      chk("gt", 8'(gt), 8'h00);
      $display("four bit done");
   endtask : t_four
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_setup();
      t_disp();
      t_data();
      t_shift();
      t_glyph();
      t_four();
      final_report();
   end
   initial begin
      // About sixteen full executions are expected; allow twenty
      repeat (20 * (EXEC_CYC + 100)) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule : lcd_char_instruction_decoder_test
